/* pkg/cpml_defines.svh */
// timing counts, reset values and widths for the control pin mode logic
`ifndef CPML_DEFINES_SVH
`define CPML_DEFINES_SVH
`define CPML_NUM_CH 4
`define CPML_MAP_A_RST 4'h4
`define CPML_MAP_B_RST 4'h8
`define CPML_OUT_RST 4'h0
`define CPML_CLK_MHZ 100
`define CPML_IDLE2SLEEP_US 100
`define CPML_SLEEP2IDLE_US 100
`define CPML_IDLE2SLEEP_CYC (`CPML_IDLE2SLEEP_US * `CPML_CLK_MHZ)
`define CPML_SLEEP2IDLE_CYC (`CPML_SLEEP2IDLE_US * `CPML_CLK_MHZ)
`endif

/* pkg/cpml_pkg.sv */
// types of the control pin mode logic
package cpml_pkg;
   typedef enum logic [1:0] {
      CPML_SLEEP,
      CPML_IDLE,
      CPML_ACTIVE,
      CPML_LIMP
   } cpml_mode_e;
endpackage : cpml_pkg

/* hw/cpml_sync2.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module cpml_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : cpml_sync2

/* hw/cpml_top.sv */
// control pin mode logic: input mapping, mode choice, register reset, serial blocking
// What this block does
// - reset maps input a to ch2, b to ch3
// - each input has its own programmable map
// - channel drive ORs output register and mapped inputs
// - report synchronised input pin levels
// - input status also works in limp home
// - idle low, input high: limp home, default channels
// - idle low, all inputs low: sleep
// - idle low resets serial registers
// - sleep disables undervoltage detectors
// - sleep refuses serial, serial enable stays low
// - both supplies low: stages off, registers reset
// - digital undervoltage blocks serial, resets registers
// - low analog range keeps on channels on
// - low analog range need not turn on
// - mode from idle, inputs, outputs, activate bit
`timescale 1ns/1ns
`include "cpml_defines.svh"
module cpml_top #(
   parameter int NUM_CH = `CPML_NUM_CH,
   parameter int IDLE2SLEEP_CYC = `CPML_IDLE2SLEEP_CYC,
   parameter int SLEEP2IDLE_CYC = `CPML_SLEEP2IDLE_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_direct_input_a,
   input wire logic i_direct_input_b,
   input wire logic i_idle,
   input wire logic i_vdd_uv,
   input wire logic i_vs_uv,
   input wire logic i_low_battery_operating_range,
   input wire logic i_wr_map_a,
   input wire logic i_wr_map_b,
   input wire logic i_wr_out,
   input wire logic i_wr_act,
   input wire logic [NUM_CH-1:0] i_wr_data,
   output logic [NUM_CH-1:0] o_ch_drive,
   output logic [NUM_CH-1:0] o_input_a_channel_map,
   output logic [NUM_CH-1:0] o_input_b_channel_map,
   output logic [NUM_CH-1:0] o_out_ctrl,
   output logic o_hw_config_activate_bit,
   output logic [1:0] o_input_level_status,
   output logic [1:0] o_mode,
   output logic o_serial_enable,
   output logic o_uv_detect_enable
);
   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   // idle and inputs share one synchroniser so they leave it aligned; limp home sees idle only after its qualification delay
   logic [2:0] pins_sync;
   cpml_sync2 #(.WIDTH(3)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_async({i_idle, i_direct_input_b, i_direct_input_a}),
      .o_sync(pins_sync)
   );
   logic in_a;
   logic in_b;
   logic idle_raw;
   assign in_a = pins_sync[0];
   assign in_b = pins_sync[1];
   assign idle_raw = pins_sync[2];

   // ----------------------------------------
   // idle pin qualification
   // ----------------------------------------
   // the idle level is accepted only after it has held for the transition time;
   // glitches shorter than that never change mode or wipe registers
   localparam int CNT_W = $clog2((IDLE2SLEEP_CYC > SLEEP2IDLE_CYC ?
                                  IDLE2SLEEP_CYC : SLEEP2IDLE_CYC) + 1);
   logic idle_q;
   logic [CNT_W-1:0] idle_cnt;
   logic [CNT_W-1:0] idle_lim;
   assign idle_lim = idle_q ? CNT_W'(IDLE2SLEEP_CYC - 1) : CNT_W'(SLEEP2IDLE_CYC - 1);
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         idle_q <= 1'b0;
         idle_cnt <= '0;
      end else if (idle_raw == idle_q) begin
         idle_cnt <= '0;
      end else if (idle_cnt >= idle_lim) begin
         idle_q <= idle_raw;
         idle_cnt <= '0;
      end else begin
         idle_cnt <= idle_cnt + CNT_W'(1);
      end
   end

   // ----------------------------------------
   // mode choice
   // ----------------------------------------
   logic any_in;
   logic regs_clear;
   cpml_pkg::cpml_mode_e next_mode;
   cpml_pkg::cpml_mode_e mode;
   assign any_in = in_a | in_b;
   // registers held at default while idle low or digital supply is under voltage
   assign regs_clear = !idle_q || i_vdd_uv;
   always_comb begin
      if (!idle_q) begin
         next_mode = any_in ? cpml_pkg::CPML_LIMP : cpml_pkg::CPML_SLEEP;
      end else if (o_hw_config_activate_bit || (|o_out_ctrl)) begin
         next_mode = cpml_pkg::CPML_ACTIVE;
      end else begin
         next_mode = cpml_pkg::CPML_IDLE;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode <= cpml_pkg::CPML_SLEEP;
      end else begin
         mode <= next_mode;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mode <= 2'h0;
      end else begin
         o_mode <= next_mode;
      end
   end

   // ----------------------------------------
   // serially written registers
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_input_a_channel_map <= NUM_CH'(`CPML_MAP_A_RST);
         o_input_b_channel_map <= NUM_CH'(`CPML_MAP_B_RST);
         o_out_ctrl <= NUM_CH'(`CPML_OUT_RST);
         o_hw_config_activate_bit <= 1'b0;
      end else if (regs_clear) begin
         o_input_a_channel_map <= NUM_CH'(`CPML_MAP_A_RST);
         o_input_b_channel_map <= NUM_CH'(`CPML_MAP_B_RST);
         o_out_ctrl <= NUM_CH'(`CPML_OUT_RST);
         o_hw_config_activate_bit <= 1'b0;
      end else begin
         if (i_wr_map_a) begin
            o_input_a_channel_map <= i_wr_data;
         end
         if (i_wr_map_b) begin
            o_input_b_channel_map <= i_wr_data;
         end
         if (i_wr_out) begin
            o_out_ctrl <= i_wr_data;
         end
         if (i_wr_act) begin
            o_hw_config_activate_bit <= i_wr_data[0];
         end
      end
   end

   // ----------------------------------------
   // channel drive
   // ----------------------------------------
   logic [NUM_CH-1:0] req;
   logic [NUM_CH-1:0] map_a_eff;
   logic [NUM_CH-1:0] map_b_eff;
   // in limp home the registers are at default, so the default map applies;
   // forcing it here keeps the fail-safe map even if a clear were ever skipped
   always_comb begin
      case (mode)
         cpml_pkg::CPML_LIMP: begin
            map_a_eff = NUM_CH'(`CPML_MAP_A_RST);
            map_b_eff = NUM_CH'(`CPML_MAP_B_RST);
         end
         default: begin
            map_a_eff = o_input_a_channel_map;
            map_b_eff = o_input_b_channel_map;
         end
      endcase
   end
   assign req = o_out_ctrl | (map_a_eff & {NUM_CH{in_a}}) |
                (map_b_eff & {NUM_CH{in_b}});
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ch_drive <= '0;
      end else if (i_vs_uv && i_vdd_uv) begin
         // both supplies low outranks the low battery hold
         o_ch_drive <= '0;
      end else if (i_low_battery_operating_range) begin
         // only turn-offs are honoured; a new turn-on waits for normal supply
         o_ch_drive <= o_ch_drive & req;
      end else begin
         o_ch_drive <= req;
      end
   end

   // ----------------------------------------
   // status and supply control
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_input_level_status <= 2'h0;
      end else begin
         o_input_level_status <= {in_b, in_a};
      end
   end
   // enables follow next_mode so they switch on the same edge as o_mode
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_serial_enable <= 1'b0;
         // detectors run through reset so a supply dip is never missed
         o_uv_detect_enable <= 1'b1;
      end else begin
         case (next_mode)
            cpml_pkg::CPML_SLEEP: begin
               o_serial_enable <= 1'b0;
               o_uv_detect_enable <= 1'b0;
            end
            default: begin
               o_serial_enable <= !i_vdd_uv;
               o_uv_detect_enable <= 1'b1;
            end
         endcase
      end
   end
endmodule : cpml_top

/* bench/cpml_host_model.sv */
// host side model driving the direct input and idle pins
`timescale 1ns/1ns
module cpml_host_model #(
   parameter int HOLD = 8
) (
   input wire logic i_ref_clk,
   input wire logic [2:0] i_req,
   output logic [2:0] o_pins = 3'h0
);
   int held = 0;
   always @(posedge i_ref_clk) begin
      o_pins[1:0] <= i_req[1:0];
      // a new idle level waits until the old one was held long enough
      if (held >= HOLD && o_pins[2] != i_req[2]) begin
         o_pins[2] <= i_req[2];
         held <= 0;
      end else begin
         held <= held + 1;
      end
   end
endmodule : cpml_host_model

/* bench/cpml_top_asserts.sv */
// port assertions of the control pin mode logic
`timescale 1ns/1ns
module cpml_top_asserts #(
   parameter int NUM_CH = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_direct_input_a,
   input wire logic i_vdd_uv,
   input wire logic i_vs_uv,
   input wire logic i_low_battery_operating_range,
   input wire logic [NUM_CH-1:0] o_ch_drive,
   input wire logic [NUM_CH-1:0] o_input_a_channel_map,
   input wire logic [NUM_CH-1:0] o_input_b_channel_map,
   input wire logic [NUM_CH-1:0] o_out_ctrl,
   input wire logic [1:0] o_input_level_status,
   input wire logic [1:0] o_mode,
   input wire logic o_serial_enable,
   input wire logic o_uv_detect_enable
);
   wire logic [1:0] s = o_input_level_status;
   wire logic [NUM_CH-1:0] want = o_out_ctrl | ({NUM_CH{s[0]}} & o_input_a_channel_map)
      | ({NUM_CH{s[1]}} & o_input_b_channel_map);
   wire logic calm = !i_vdd_uv && !i_vs_uv && !i_low_battery_operating_range;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // drive lags its sources by a cycle, so it is judged only once they hold still
   drive_or_a: assert property (o_mode inside {2'h1, 2'h2} && calm && $past(calm)
      && $stable({o_mode, want}) |-> o_ch_drive == want) else $error("drive mismatch");
   limp_out_a: assert property (o_mode == 2'h3 |-> o_out_ctrl == 0)
      else $error("limp out set");
   // in limp home the drive one cycle on shows the default map of the status levels
   limp_drive_a: assert property ($past(o_mode) == 2'h3 && $past(calm)
      |-> o_ch_drive == {s, 2'h0}) else $error("limp drive");
   sleep_regs_a: assert property (o_mode == 2'h0 |-> !o_serial_enable
      && o_input_a_channel_map == 4'h4 && o_input_b_channel_map == 4'h8) else $error("sleep regs");
   uv_off_a: assert property (o_mode == 2'h0 [*3] |-> !o_uv_detect_enable)
      else $error("uv detect on");
   vdd_clr_a: assert property (i_vdd_uv |=> !o_serial_enable && o_out_ctrl == 0)
      else $error("vdd uv regs");
   both_uv_a: assert property ((i_vdd_uv && i_vs_uv) [*2] |=> o_ch_drive == 0)
      else $error("both uv drive");
   no_turn_on_a: assert property (i_low_battery_operating_range
      && $past(i_low_battery_operating_range) |-> (o_ch_drive & ~$past(o_ch_drive)) == 0)
      else $error("low battery turn on");
   status_lag_a: assert property ($rose(i_direct_input_a) |-> ##2 !s[0] ##1 s[0])
      else $error("status lag");
   cover property (o_mode == 2'h3);
   cover property (o_mode == 2'h2 && |o_ch_drive);
   cover property (i_low_battery_operating_range && |o_ch_drive);
endmodule : cpml_top_asserts
bind cpml_top cpml_top_asserts #(.NUM_CH(NUM_CH)) u_asserts (.i_ref_clk, .i_nrst,
   .i_direct_input_a, .i_vdd_uv, .i_vs_uv, .i_low_battery_operating_range, .o_ch_drive,
   .o_input_a_channel_map, .o_input_b_channel_map, .o_out_ctrl, .o_input_level_status,
   .o_mode, .o_serial_enable, .o_uv_detect_enable);

/* bench/cpml_top_tb.sv */
// self-checking testbench of the control pin mode logic
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("unexpected at %0t: got %h", $time, a); end end
module cpml_top_tb;
   logic i_ref_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic vdd = 1'b0, vs = 1'b0, lb = 1'b0;
   logic [2:0] req = 3'h0;
   logic [3:0] we = 4'h0, wd = 4'h0;
   wire logic [2:0] pins;
   wire logic [3:0] drv, ma, mb, oc;
   wire logic act, ser, uvd;
   wire logic [1:0] st, md;
   int num_errors = 0, tests_run = 0;
   always #5 i_ref_clk = ~i_ref_clk;
   cpml_host_model #(.HOLD(8)) u_host (.i_ref_clk, .i_req(req), .o_pins(pins));
   cpml_top #(.IDLE2SLEEP_CYC(4), .SLEEP2IDLE_CYC(4)) u_dut (.i_ref_clk, .i_nrst,
      .i_direct_input_a(pins[0]), .i_direct_input_b(pins[1]), .i_idle(pins[2]),
      .i_vdd_uv(vdd), .i_vs_uv(vs), .i_low_battery_operating_range(lb), .i_wr_map_a(we[0]),
      .i_wr_map_b(we[1]), .i_wr_out(we[2]), .i_wr_act(we[3]), .i_wr_data(wd),
      .o_ch_drive(drv), .o_input_a_channel_map(ma), .o_input_b_channel_map(mb),
      .o_out_ctrl(oc), .o_hw_config_activate_bit(act), .o_input_level_status(st),
      .o_mode(md), .o_serial_enable(ser), .o_uv_detect_enable(uvd));
   task wr(input int i, input logic [3:0] d);
      we <= 4'h1 << i;
      wd <= d;
      @(posedge i_ref_clk);
      we <= 4'h0;
      repeat (5) @(posedge i_ref_clk);
   endtask : wr
   task go(input logic [2:0] r, input logic [1:0] m);
      int n;
      req <= r;
      n = 0;
      while (md !== m && n < 80) begin
         @(posedge i_ref_clk);
         n++;
      end
      repeat (6) @(posedge i_ref_clk);
      `CHK(md, m)
   endtask : go
   task t_map;
      go(3'h4, 2'h1);
      `CHK({ma, mb, oc}, 12'h480)
      go(3'h5, 2'h1);
      `CHK({st, drv}, 6'h14)
      wr(0, 4'h3);
      wr(1, 4'h0);
      wr(2, 4'h8);
      go(3'h7, 2'h2);
      `CHK({st, drv}, 6'h3B)
      wr(2, 4'h0);
      wr(3, 4'h1);
      `CHK({act, md}, 3'h6)
      $display("map test done");
   endtask : t_map
   task t_limp;
      go(3'h1, 2'h3);
      `CHK({ma, mb, oc, drv, st}, 18'h12011)
      go(3'h0, 2'h0);
      `CHK({ser, uvd, act}, 3'h0)
      $display("limp test done");
   endtask : t_limp
   task t_supply;
      go(3'h5, 2'h1);
      wr(2, 4'h1);
      vdd <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      `CHK({ser, oc}, 5'h0)
      vs <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      `CHK(drv, 4'h0)
      vdd <= 1'b0;
      vs <= 1'b0;
      go(3'h4, 2'h1);
      wr(2, 4'h1);
      lb <= 1'b1;
      wr(2, 4'h3);
      `CHK(drv, 4'h1)
      wr(2, 4'h0);
      `CHK(drv, 4'h0)
      lb <= 1'b0;
      $display("supply test done");
   endtask : t_supply
   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #100000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_nrst <= 1'b1;
      t_map;
      t_limp;
      t_supply;
      report_and_stop;
   end
endmodule : cpml_top_tb
